/* fft_butterfly_pipeline_test.sv */
// Self-checking bench for the butterfly pipeline
module fft_butterfly_pipeline_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        start = 1'b0;
  logic        tw_use_gen = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic [11:0] a_addr = 12'h0;
  logic [11:0] b_addr = 12'h0;
  logic [15:0] tw_rom_re = 16'h0;
  logic [15:0] tw_rom_im = 16'h0;
  logic [15:0] tw_gen_re = 16'h0;
  logic [15:0] tw_gen_im = 16'h0;
  wire         start_ready, mem_re, mem_we, bfly_done;
  wire [1:0]   mem_tag, bfly_done_tag;
  wire [11:0]  mem_addr;
  wire [15:0]  mem_wdata_re, mem_wdata_im, mem_rdata_re, mem_rdata_im;
  logic [1:0]  exp_tag = 2'h0;
  logic [11:0] q_addr[$];
  logic [31:0] q_val[$];
  int          num_errors = 0;
  int          num_checks = 0;
  always #5 ref_clk = ~ref_clk;
  fftbf_pipeline DUT (.ref_clk, .nrst, .mode, .start, .start_ready,
    .a_addr, .b_addr, .tw_use_gen, .tw_rom_re, .tw_rom_im, .tw_gen_re,
    .tw_gen_im, .mem_re, .mem_we, .mem_addr, .mem_tag, .mem_wdata_re,
    .mem_wdata_im, .mem_rdata_re, .mem_rdata_im, .bfly_done, .bfly_done_tag);
  fftbf_sram_model u_sram (.ref_clk, .mem_re, .mem_we, .mem_addr,
    .mem_wdata_re, .mem_wdata_im, .mem_rdata_re, .mem_rdata_im);
  function automatic logic [15:0] hi(logic [15:0] x, logic [15:0] y);
    logic signed [31:0] p;
    p = $signed(x) * $signed(y);
    return p[31:16];
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(negedge ref_clk) begin
    if (bfly_done === 1'b1) begin
      chk({30'h0, bfly_done_tag}, {30'h0, exp_tag});
      exp_tag = exp_tag == 2'h2 ? 2'h0 : exp_tag + 2'h1;
    end
  end
  // Start held high while not ready, so refused requests are exercised
  task automatic run_bf(input logic g, input logic [11:0] a, output int n);
    logic [15:0] ar, ai, br, bi, wr, wi, pr, pm;
    ar = {a[7:0], 8'hff};
    ai = 16'h7fff - a;
    br = 16'h8000 + a * 16'h0111;
    bi = 16'h00ff << a[1:0];
    wr = 16'h7fff - a * 16'h1000;
    wi = 16'h8000 + a * 16'h0777;
    pr = hi(br, wr) - hi(bi, wi);
    pm = hi(bi, wr) + hi(br, wi);
    {u_sram.m_re[a], u_sram.m_im[a]} = {ar, ai};
    {u_sram.m_re[a + 12'h1], u_sram.m_im[a + 12'h1]} = {br, bi};
    q_addr.push_back(a);
    q_val.push_back({ar + pr, ai + pm});
    q_addr.push_back(a + 12'h1);
    q_val.push_back({ar - pr, ai - pm});
    n = 0;
    @(negedge ref_clk);
    {start, a_addr, b_addr, tw_use_gen} = {1'b1, a, a + 12'h1, g};
    {tw_rom_re, tw_rom_im, tw_gen_re, tw_gen_im} =
      g ? {~wr, ~wi, wr, wi} : {wr, wi, ~wr, ~wi};
    while (start_ready !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    start = 1'b0;
  endtask
  task automatic drain;
    repeat (14) @(negedge ref_clk);
    while (q_addr.size() > 0) begin
      chk({u_sram.m_re[q_addr[0]], u_sram.m_im[q_addr[0]]}, q_val[0]);
      void'(q_addr.pop_front());
      void'(q_val.pop_front());
    end
  endtask
  task automatic t_serial;
    int n;
    mode = 2'h0;
    run_bf(1'b0, 12'h010, n);
    run_bf(1'b1, 12'h012, n);
    chk(n, 6);
    mode = 2'h3;
    run_bf(1'b0, 12'h014, n);
    chk(n, 6);
    drain();
    $display("Test serial done");
  endtask
  task automatic t_loop5;
    int n;
    mode = 2'h1;
    for (int i = 0; i < 3; i++) begin
      run_bf(i[0], 12'h020 + 12'(2 * i), n);
      if (i > 0) chk(n, 3);
    end
    drain();
    $display("Test loop5 done");
  endtask
  // Four back to back keeps three in flight
  task automatic t_loop4;
    int n;
    mode = 2'h2;
    for (int i = 0; i < 4; i++) begin
      run_bf(i[0], 12'h030 + 12'(2 * i), n);
      if (i > 0) chk(n, 2);
    end
    drain();
    $display("Test loop4 done");
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    t_serial();
    t_loop5();
    t_loop4();
    tally_and_finish();
  end
  // Tests need about a hundred cycles; this is ample margin
  initial begin
    #50000;
    num_errors++;
    tally_and_finish();
  end
endmodule

/* fftbf_checker.sv */
// Port checker for the butterfly pipeline
module fftbf_checker #(
  parameter AW = 12
) (
  // Clock, reset, requests
  input wire          ref_clk,
  input wire          nrst,
  input wire [1:0]    mode,
  input wire          start,
  input wire          start_ready,
  input wire [AW-1:0] a_addr,
  input wire [AW-1:0] b_addr,
  // Data bus and completion
  input wire          mem_re,
  input wire          mem_we,
  input wire [AW-1:0] mem_addr,
  input wire [1:0]    mem_tag,
  input wire          bfly_done,
  input wire [1:0]    bfly_done_tag
);
  wire       take = start && start_ready;
  wire [3:0] gap = mode == 2'h1 ? 4'h5 : mode == 2'h2 ? 4'h4 : 4'h8;
  reg  [3:0] since;
  reg  [1:0] tag;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      since <= 4'hf;
      tag   <= 2'h0;
    end else if (take) begin
      since <= 4'h1;
      tag   <= tag == 2'h2 ? 2'h0 : tag + 2'h1;
    end else if (since != 4'hf) begin
      since <= since + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  property p_ready;
    start_ready == (since == gap || since >= 4'hc);
  endproperty
  a_ready: assert property (p_ready) else $error("bad ready");
  property p_rd_b;
    take |-> ##2 mem_re && mem_addr == $past(b_addr, 2)
      && mem_tag == $past(tag, 2);
  endproperty
  a_rd_b: assert property (p_rd_b) else $error("bad B read");
  property p_rd_a;
    take |-> ##4 mem_re && mem_addr == $past(a_addr, 4);
  endproperty
  a_rd_a: assert property (p_rd_a) else $error("bad A read");
  property p_wr_a;
    take |-> ##11 mem_we && !bfly_done && mem_addr == $past(a_addr, 11);
  endproperty
  a_wr_a: assert property (p_wr_a) else $error("bad A write");
  property p_wr_b;
    take |-> ##13 mem_we && bfly_done && mem_addr == $past(b_addr, 13);
  endproperty
  a_wr_b: assert property (p_wr_b) else $error("bad B write");
  property p_done_tag;
    take |-> ##13 bfly_done_tag == $past(tag, 13);
  endproperty
  a_done_tag: assert property (p_done_tag) else $error("bad tag");
  property p_tag_match;
    bfly_done |-> bfly_done_tag == mem_tag && mem_tag != 2'h3;
  endproperty
  a_tag_match: assert property (p_tag_match) else $error("tag skew");
  property p_excl;
    !(mem_re && mem_we);
  endproperty
  a_excl: assert property (p_excl) else $error("bus clash");
  c_serial: cover property (take && mode == 2'h0);
  c_loop5: cover property (take && mode == 2'h1);
  c_loop4: cover property (take && mode == 2'h2);
endmodule

bind fftbf_pipeline fftbf_checker #(.AW(AW)) u_chk (.ref_clk, .nrst,
  .mode, .start, .start_ready, .a_addr, .b_addr, .mem_re, .mem_we,
  .mem_addr, .mem_tag, .bfly_done, .bfly_done_tag);

/* fftbf_defs.vh */
// Constants for the FFT butterfly pipeline
`ifndef FFTBF_DEFS_VH
`define FFTBF_DEFS_VH

// Data, slice, product and address widths
`define FFTBF_DW        16
`define FFTBF_SLICE_W   8
`define FFTBF_PW        32
`define FFTBF_AW        12

// Schedule modes
`define FFTBF_MODE_W      2
`define FFTBF_MODE_SERIAL 2'h0
`define FFTBF_MODE_LOOP5  2'h1
`define FFTBF_MODE_LOOP4  2'h2

// Start intervals in cycles for each mode
`define FFTBF_GAP_W      4
`define FFTBF_GAP_SERIAL 4'h8
`define FFTBF_GAP_LOOP5  4'h5
`define FFTBF_GAP_LOOP4  4'h4
// Gap count at which the last start has reached stage 11; held once the pipe empties
`define FFTBF_GAP_IDLE   4'hc

// Stage numbers, counted from the start cycle
// Bus stages 0, 2, 9, 11: no two differ by 4, 5, 8 or 10
`define FFTBF_ST_RD_B   0
`define FFTBF_ST_RD_A   2
`define FFTBF_ST_CAP_B  1
`define FFTBF_ST_CAP_A  3
`define FFTBF_ST_M0     2
`define FFTBF_ST_M1     3
`define FFTBF_ST_M2     4
`define FFTBF_ST_M3     5
`define FFTBF_ST_RDIFF  4
`define FFTBF_ST_ISUM   6
`define FFTBF_ST_WR_A   9
`define FFTBF_ST_IBOUT  9
`define FFTBF_ST_WR_B   11
`define FFTBF_NSTAGE    12

// Butterfly tags: three in flight
`define FFTBF_TAG_W     2
`define FFTBF_NTAG      3
`define FFTBF_TAG_LAST  2'h2

`endif

/* fftbf_pipeline.v */
// Radix-2 butterfly processor with one shared multiplier
`include "fftbf_defs.vh"

module fftbf_pipeline #(
  parameter DW = `FFTBF_DW,
  parameter AW = `FFTBF_AW
) (
  // Clock and reset
  input  wire          ref_clk,
  input  wire          nrst,
  // Butterfly requests
  input  wire [`FFTBF_MODE_W-1:0] mode,
  input  wire          start,
  output wire          start_ready,
  input  wire [AW-1:0] a_addr,
  input  wire [AW-1:0] b_addr,
  // Twiddle sources
  input  wire          tw_use_gen,
  input  wire [DW-1:0] tw_rom_re,
  input  wire [DW-1:0] tw_rom_im,
  input  wire [DW-1:0] tw_gen_re,
  input  wire [DW-1:0] tw_gen_im,
  // Data memory bus
  output reg           mem_re,
  output reg           mem_we,
  output reg  [AW-1:0] mem_addr,
  output reg  [`FFTBF_TAG_W-1:0] mem_tag,
  output reg  [DW-1:0] mem_wdata_re,
  output reg  [DW-1:0] mem_wdata_im,
  input  wire [DW-1:0] mem_rdata_re,
  input  wire [DW-1:0] mem_rdata_im,
  // Completion
  output reg           bfly_done,
  output reg  [`FFTBF_TAG_W-1:0] bfly_done_tag
);

  // Per-butterfly working storage, indexed by tag
  reg [DW-1:0] ar   [0:`FFTBF_NTAG-1];
  reg [DW-1:0] ai   [0:`FFTBF_NTAG-1];
  reg [DW-1:0] br   [0:`FFTBF_NTAG-1];
  reg [DW-1:0] bi   [0:`FFTBF_NTAG-1];
  reg [DW-1:0] wr   [0:`FFTBF_NTAG-1];
  reg [DW-1:0] wi   [0:`FFTBF_NTAG-1];
  reg [DW-1:0] q0   [0:`FFTBF_NTAG-1];
  reg [DW-1:0] q1   [0:`FFTBF_NTAG-1];
  reg [DW-1:0] q2   [0:`FFTBF_NTAG-1];
  reg [DW-1:0] q3   [0:`FFTBF_NTAG-1];
  reg [DW-1:0] rdif [0:`FFTBF_NTAG-1];
  reg [DW-1:0] isum [0:`FFTBF_NTAG-1];
  reg [DW-1:0] bout [0:`FFTBF_NTAG-1];
  reg [AW-1:0] adra [0:`FFTBF_NTAG-1];
  reg [AW-1:0] adrb [0:`FFTBF_NTAG-1];

  // Stage pipe: valid bit and tag of the butterfly at each stage
  reg [`FFTBF_NSTAGE-1:0]              stv;
  reg [`FFTBF_NSTAGE*`FFTBF_TAG_W-1:0] stt;
  reg [`FFTBF_TAG_W-1:0]               cur_tag;
  reg [`FFTBF_GAP_W-1:0]               gap;
  reg [`FFTBF_GAP_W-1:0]               gap_need;
  wire go;

  function [`FFTBF_TAG_W-1:0] tag_at;
    input [`FFTBF_NSTAGE*`FFTBF_TAG_W-1:0] p;
    input integer s;
    begin
      tag_at = p[s*`FFTBF_TAG_W +: `FFTBF_TAG_W];
    end
  endfunction

  // One 8-bit slice adder/subtractor with carry cascade
  function [`FFTBF_SLICE_W:0] slice8;
    input [`FFTBF_SLICE_W-1:0] a;
    input [`FFTBF_SLICE_W-1:0] b;
    input                      sub;
    input                      cin;
    begin
      slice8 = {1'b0, a} + {1'b0, (sub ? ~b : b)}
             + {{`FFTBF_SLICE_W{1'b0}}, cin};
    end
  endfunction

  // 16-bit ALU from two cascaded slices
  function [`FFTBF_DW-1:0] alu16;
    input [`FFTBF_DW-1:0] a;
    input [`FFTBF_DW-1:0] b;
    input                 sub;
    reg   [`FFTBF_SLICE_W:0] lo;
    reg   [`FFTBF_SLICE_W:0] hi;
    begin
      lo = slice8(a[`FFTBF_SLICE_W-1:0], b[`FFTBF_SLICE_W-1:0], sub, sub);
      hi = slice8(a[`FFTBF_DW-1:`FFTBF_SLICE_W],
                  b[`FFTBF_DW-1:`FFTBF_SLICE_W], sub, lo[`FFTBF_SLICE_W]);
      alu16 = {hi[`FFTBF_SLICE_W-1:0], lo[`FFTBF_SLICE_W-1:0]};
    end
  endfunction

  // Start interval per mode
  always @* begin
    case (mode)
      `FFTBF_MODE_LOOP4: gap_need = `FFTBF_GAP_LOOP4;
      `FFTBF_MODE_LOOP5: gap_need = `FFTBF_GAP_LOOP5;
      default:           gap_need = `FFTBF_GAP_SERIAL;
    endcase
  end

  // Only the exact interval or a gap of 12 cycles or more avoids bus clashes;
  // mode must stay steady while butterflies are in flight
  assign start_ready = (gap == gap_need) || (gap == `FFTBF_GAP_IDLE);
  assign go          = start & start_ready;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stv     <= {`FFTBF_NSTAGE{1'b0}};
      stt     <= {(`FFTBF_NSTAGE*`FFTBF_TAG_W){1'b0}};
      cur_tag <= {`FFTBF_TAG_W{1'b0}};
      gap     <= `FFTBF_GAP_IDLE;
    end else begin
      stv <= {stv[`FFTBF_NSTAGE-2:0], go};
      stt <= {stt[(`FFTBF_NSTAGE-1)*`FFTBF_TAG_W-1:0], cur_tag};
      if (go) begin
        cur_tag <= (cur_tag == `FFTBF_TAG_LAST) ? {`FFTBF_TAG_W{1'b0}}
                                                : cur_tag + 2'h1;
        gap     <= 4'h1;
      end else if (gap < `FFTBF_GAP_IDLE) begin
        gap <= gap + 4'h1;
      end
    end
  end

  // Shared multiplier: Y from a slice port, X from twiddle
  reg  [DW-1:0] real_mio;
  reg  [DW-1:0] imag_mio;
  reg  [DW-1:0] mul_y;
  reg  [DW-1:0] mul_x;
  wire [`FFTBF_PW-1:0] mul_p;
  wire [DW-1:0] multiplier_result_input_port;
  wire [`FFTBF_TAG_W-1:0] mt;

  // At most one butterfly sits in the multiply stages
  assign mt = stv[`FFTBF_ST_M0] ? tag_at(stt, `FFTBF_ST_M0) :
              stv[`FFTBF_ST_M1] ? tag_at(stt, `FFTBF_ST_M1) :
              stv[`FFTBF_ST_M2] ? tag_at(stt, `FFTBF_ST_M2) :
                                  tag_at(stt, `FFTBF_ST_M3);

  always @* begin
    real_mio = br[mt];
    imag_mio = bi[mt];
    mul_y    = real_mio;
    mul_x    = wr[mt];
    if (stv[`FFTBF_ST_M1]) begin
      mul_y = imag_mio;
      mul_x = wi[mt];
    end else if (stv[`FFTBF_ST_M2]) begin
      mul_y = imag_mio;
    end else if (stv[`FFTBF_ST_M3]) begin
      mul_x = wi[mt];
    end
  end

  assign mul_p = $signed(mul_x) * $signed(mul_y);
  // Low half dropped; keeps one bit of headroom per product
  assign multiplier_result_input_port = mul_p[`FFTBF_PW-1:DW];

  // Datapath storage updates
  wire [`FFTBF_TAG_W-1:0] t_cb = tag_at(stt, `FFTBF_ST_CAP_B);
  wire [`FFTBF_TAG_W-1:0] t_ca = tag_at(stt, `FFTBF_ST_CAP_A);
  wire [`FFTBF_TAG_W-1:0] t_rd = tag_at(stt, `FFTBF_ST_RDIFF);
  wire [`FFTBF_TAG_W-1:0] t_is = tag_at(stt, `FFTBF_ST_ISUM);
  wire [`FFTBF_TAG_W-1:0] t_wa = tag_at(stt, `FFTBF_ST_WR_A);
  wire [`FFTBF_TAG_W-1:0] t_ib = tag_at(stt, `FFTBF_ST_IBOUT);
  wire [`FFTBF_TAG_W-1:0] t_wb = tag_at(stt, `FFTBF_ST_WR_B);

  always @(posedge ref_clk) begin
    if (go) begin
      adra[cur_tag] <= a_addr;
      adrb[cur_tag] <= b_addr;
      wr[cur_tag]   <= tw_use_gen ? tw_gen_re : tw_rom_re;
      wi[cur_tag]   <= tw_use_gen ? tw_gen_im : tw_rom_im;
    end
    if (stv[`FFTBF_ST_CAP_B]) begin
      br[t_cb] <= mem_rdata_re;
      bi[t_cb] <= mem_rdata_im;
    end
    if (stv[`FFTBF_ST_CAP_A]) begin
      ar[t_ca] <= mem_rdata_re;
      ai[t_ca] <= mem_rdata_im;
    end
    if (stv[`FFTBF_ST_M0])
      q0[mt] <= multiplier_result_input_port; // BR*WR
    if (stv[`FFTBF_ST_M1])
      q1[mt] <= multiplier_result_input_port; // BI*WI
    if (stv[`FFTBF_ST_M2])
      q2[mt] <= multiplier_result_input_port; // BI*WR
    if (stv[`FFTBF_ST_M3])
      q3[mt] <= multiplier_result_input_port; // BR*WI
    if (stv[`FFTBF_ST_RDIFF])
      rdif[t_rd] <= alu16(q0[t_rd], q1[t_rd], 1'b1);
    if (stv[`FFTBF_ST_ISUM])
      isum[t_is] <= alu16(q2[t_is], q3[t_is], 1'b0);
    if (stv[`FFTBF_ST_IBOUT])
      bout[t_ib] <= alu16(ai[t_ib], isum[t_ib], 1'b1);
  end

  // Data bus: one registered access per cycle
  reg              next_re;
  reg              next_we;
  reg [AW-1:0]     next_addr;
  reg [`FFTBF_TAG_W-1:0] next_tag;
  reg [DW-1:0]     next_wre;
  reg [DW-1:0]     next_wim;

  always @* begin
    next_re   = 1'b0;
    next_we   = 1'b0;
    next_addr = mem_addr;
    next_tag  = mem_tag;
    next_wre  = mem_wdata_re;
    next_wim  = mem_wdata_im;
    if (stv[`FFTBF_ST_RD_B]) begin
      next_re   = 1'b1;
      next_tag  = tag_at(stt, `FFTBF_ST_RD_B);
      next_addr = adrb[next_tag];
    end else if (stv[`FFTBF_ST_RD_A]) begin
      next_re   = 1'b1;
      next_tag  = tag_at(stt, `FFTBF_ST_RD_A);
      next_addr = adra[next_tag];
    end else if (stv[`FFTBF_ST_WR_A]) begin
      next_we   = 1'b1;
      next_tag  = t_wa;
      next_addr = adra[t_wa];
      next_wre  = alu16(ar[t_wa], rdif[t_wa], 1'b0);
      next_wim  = alu16(ai[t_wa], isum[t_wa], 1'b0);
    end else if (stv[`FFTBF_ST_WR_B]) begin
      next_we   = 1'b1;
      next_tag  = t_wb;
      next_addr = adrb[t_wb];
      next_wre  = alu16(ar[t_wb], rdif[t_wb], 1'b1);
      next_wim  = bout[t_wb];
    end
  end

  // Cycle at stage 0 uses registers captured at the start
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mem_re        <= 1'b0;
      mem_we        <= 1'b0;
      mem_addr      <= {AW{1'b0}};
      mem_tag       <= {`FFTBF_TAG_W{1'b0}};
      mem_wdata_re  <= {DW{1'b0}};
      mem_wdata_im  <= {DW{1'b0}};
      bfly_done     <= 1'b0;
      bfly_done_tag <= {`FFTBF_TAG_W{1'b0}};
    end else begin
      mem_re        <= next_re;
      mem_we        <= next_we;
      mem_addr      <= next_addr;
      mem_tag       <= next_tag;
      mem_wdata_re  <= next_wre;
      mem_wdata_im  <= next_wim;
      bfly_done     <= stv[`FFTBF_ST_WR_B];
      bfly_done_tag <= t_wb;
    end
  end

endmodule

/* fftbf_sram_model.sv */
// Data RAM model on the butterfly data bus
module fftbf_sram_model (
  // Clock
  input  wire         ref_clk,
  // Bus from the pipeline
  input  wire         mem_re,
  input  wire         mem_we,
  input  wire  [11:0] mem_addr,
  input  wire  [15:0] mem_wdata_re,
  input  wire  [15:0] mem_wdata_im,
  output logic [15:0] mem_rdata_re,
  output logic [15:0] mem_rdata_im
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] m_re [4096];
  logic [15:0] m_im [4096];
  logic [31:0] last = 32'h0;
  // Off the strobe the bus shows no stale word
  assign mem_rdata_re = mem_re ? m_re[mem_addr] : ~last[31:16];
  assign mem_rdata_im = mem_re ? m_im[mem_addr] : ~last[15:0];
  always @(posedge ref_clk) begin
    if (mem_re) last <= {m_re[mem_addr], m_im[mem_addr]};
    if (mem_we) m_re[mem_addr] <= mem_wdata_re;
    if (mem_we) m_im[mem_addr] <= mem_wdata_im;
  end
endmodule
